// ===== core/rism_defines.svh
// Offsets, field positions, reset values and timing counts of the interrupt status block
`ifndef RISM_DEFINES_SVH
`define RISM_DEFINES_SVH
`define RISM_OFS_STATUS 6'h0c
`define RISM_OFS_MASK 6'h0d
`define RISM_STATUS_RST 8'h00
`define RISM_MASK_RST 8'h00
`define RISM_BIT_TX_END 7
`define RISM_BIT_RX 6
`define RISM_BIT_FIFO 5
`define RISM_BIT_CRC 4
`define RISM_BIT_HDR 3
`define RISM_BIT_SHORT 2
`define RISM_BIT_PRE 1
`define RISM_BIT_NORESP 0
`define RISM_MASK_USED 8'h3f
`define RISM_FIFO_LOW 5'h08
`define RISM_FIFO_HIGH 5'h10
`define RISM_FIFO_TWO 5'h02
`define RISM_STEP_CYCLES 16'h0280
`define RISM_STEP_LAST 16'h027f
`endif

// ===== core/rism_pkg.sv
// Types of the interrupt status block
package rism_pkg;
    typedef struct packed {
        logic tx_done;
        logic rx_start;
        logic rx_done;
        logic crc_error;
        logic header_high;
        logic short_reply;
        logic preamble_error;
    } rism_events_t;
    typedef struct packed {
        logic [5:0] addr;
        logic wr;
        logic rd;
        logic [7:0] wdata;
    } rism_host_req_t;
    typedef enum logic [1:0] {RISM_IDLE, RISM_TX, RISM_WAIT} rism_timer_t;
endpackage : rism_pkg

// ===== core/rism_irq.sv
// Interrupt status and mask registers with no-response timer
`timescale 1ns/1ps
`include "rism_defines.svh"
module rism_irq (
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic chip_en_in,
    input wire rism_pkg::rism_host_req_t host_req_in,
    input wire rism_pkg::rism_events_t events_in,
    input wire logic transmitting_in,
    input wire logic tx_direction_in,
    input wire logic [4:0] fifo_level_in,
    input wire logic crc_check_en_in,
    input wire logic alt_interrupt_mode_select_in,
    input wire logic [7:0] noresp_steps_in,
    output logic [7:0] rdata_out,
    output logic irq_out
);
    import rism_pkg::*;

    logic [7:0] status_r;
    logic [7:0] status_nxt;
    logic [7:0] set_vec;
    logic [7:0] mask_r;
    logic [4:0] fifo_prev_r;
    logic fifo_low_evt;
    logic fifo_high_evt;
    logic two_bytes_ready_flag;
    logic crc_fail_flag;
    logic short_reply_flag;
    logic preamble_fail_flag;
    logic read_status;
    logic write_mask;
    logic noresp_hit;
    rism_timer_t tstate_r;
    logic [7:0] step_cnt_r;
    logic [15:0] cyc_cnt_r;

    assign read_status = host_req_in.rd && host_req_in.addr == `RISM_OFS_STATUS;
    assign write_mask = host_req_in.wr && host_req_in.addr == `RISM_OFS_MASK;

    // FIFO level crossings, edge based so a steady level fires once
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            fifo_prev_r <= 5'h00;
        end else begin
            fifo_prev_r <= fifo_level_in;
        end
    end
    assign fifo_low_evt = tx_direction_in && fifo_level_in < `RISM_FIFO_LOW
        && fifo_prev_r >= `RISM_FIFO_LOW;
    assign fifo_high_evt = !tx_direction_in && fifo_level_in > `RISM_FIFO_HIGH
        && fifo_prev_r <= `RISM_FIFO_HIGH;
    // two bytes present, caught on the rising crossing
    assign two_bytes_ready_flag = fifo_level_in >= `RISM_FIFO_TWO
        && fifo_prev_r < `RISM_FIFO_TWO;
    // CRC errors suppressed when checking is off
    assign crc_fail_flag = events_in.crc_error && crc_check_en_in;
    assign short_reply_flag = events_in.short_reply;
    assign preamble_fail_flag = events_in.preamble_error;

    // level walks down past the low mark while sending
    sequence s_fifo_falls;
        tx_direction_in && fifo_level_in >= `RISM_FIFO_LOW
        ##1 chip_en_in && tx_direction_in && fifo_level_in < `RISM_FIFO_LOW;
    endsequence
    // level climbs past the high mark while receiving
    sequence s_fifo_rises;
        !tx_direction_in && fifo_level_in <= `RISM_FIFO_HIGH
        ##1 chip_en_in && !tx_direction_in && fifo_level_in > `RISM_FIFO_HIGH;
    endsequence
    // second byte lands while the alternate meaning is selected
    sequence s_second_byte;
        fifo_level_in < `RISM_FIFO_TWO
        ##1 chip_en_in && alt_interrupt_mode_select_in && fifo_level_in >= `RISM_FIFO_TWO;
    endsequence
    a_fifo_low_set: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        s_fifo_falls |=> status_r[`RISM_BIT_FIFO])
        else $error("fifo low flag missing");
    a_fifo_high_set: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        s_fifo_rises |=> status_r[`RISM_BIT_FIFO])
        else $error("fifo high flag missing");
    a_two_bytes_set: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        s_second_byte |=> status_r[`RISM_BIT_HDR])
        else $error("two bytes flag missing");

    // Event vector into the status bits
    always_comb begin
        set_vec = 8'h00;
        set_vec[`RISM_BIT_TX_END] = events_in.tx_done;
        set_vec[`RISM_BIT_RX] = events_in.rx_start | events_in.rx_done;
        set_vec[`RISM_BIT_FIFO] = fifo_low_evt | fifo_high_evt;
        set_vec[`RISM_BIT_CRC] = crc_fail_flag;
        set_vec[`RISM_BIT_HDR] = alt_interrupt_mode_select_in ? two_bytes_ready_flag
            : events_in.header_high;
        set_vec[`RISM_BIT_SHORT] = short_reply_flag;
        set_vec[`RISM_BIT_PRE] = alt_interrupt_mode_select_in ? events_in.rx_done
            : preamble_fail_flag;
        set_vec[`RISM_BIT_NORESP] = noresp_hit;
    end

    // sticky flags; a set in the read cycle survives the clear
    always_comb begin
        status_nxt = status_r;
        if (read_status) begin
            status_nxt = 8'h00;
        end
        status_nxt = status_nxt | set_vec;
    end

    // cleared on reset and while chip enable is low
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            status_r <= `RISM_STATUS_RST;
        end else if (!chip_en_in) begin
            status_r <= `RISM_STATUS_RST;
        end else begin
            status_r <= status_nxt;
        end
    end

    // reserved mask bits are not stored and read as zero
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            mask_r <= `RISM_MASK_RST;
        end else if (!chip_en_in) begin
            mask_r <= `RISM_MASK_RST;
        end else if (write_mask) begin
            mask_r <= host_req_in.wdata & `RISM_MASK_USED;
        end
    end

    // Read data registered; captured before the clear takes effect
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            rdata_out <= 8'h00;
        end else if (host_req_in.rd) begin
            unique case (host_req_in.addr)
                `RISM_OFS_STATUS: rdata_out <= status_r;
                `RISM_OFS_MASK: rdata_out <= mask_r;
                default: rdata_out <= 8'h00;
            endcase
        end
    end

    // TX and RX flags bypass the mask
    // follows status, so the read clear drops it
    assign irq_out = |(status_r & {2'b11, mask_r[5:0]});

    // no-response timer, starts at TX end, stops at reply start
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            tstate_r <= RISM_IDLE;
            step_cnt_r <= 8'h00;
            cyc_cnt_r <= 16'h0000;
        end else if (!chip_en_in) begin
            tstate_r <= RISM_IDLE;
            step_cnt_r <= 8'h00;
            cyc_cnt_r <= 16'h0000;
        end else begin
            unique case (tstate_r)
                RISM_IDLE: begin
                    if (transmitting_in) begin
                        tstate_r <= RISM_TX;
                    end
                end
                RISM_TX: begin
                    if (events_in.tx_done && noresp_steps_in != 8'h00) begin
                        tstate_r <= RISM_WAIT;
                        step_cnt_r <= 8'h00;
                        cyc_cnt_r <= 16'h0000;
                    end else if (events_in.tx_done) begin
                        tstate_r <= RISM_IDLE;
                    end
                end
                RISM_WAIT: begin
                    if (events_in.rx_start || noresp_hit) begin
                        tstate_r <= RISM_IDLE;
                    end else if (cyc_cnt_r == `RISM_STEP_LAST) begin
                        cyc_cnt_r <= 16'h0000;
                        step_cnt_r <= step_cnt_r + 8'h01;
                    end else begin
                        cyc_cnt_r <= cyc_cnt_r + 16'h0001;
                    end
                end
                // Unused fourth code falls back to idle
                default: tstate_r <= RISM_IDLE;
            endcase
        end
    end
    assign noresp_hit = tstate_r == RISM_WAIT && !events_in.rx_start
        && step_cnt_r == noresp_steps_in;

    sequence s_timer_armed;
        chip_en_in && tstate_r == RISM_TX && events_in.tx_done && noresp_steps_in != 8'h00;
    endsequence
    a_timer_arm: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        s_timer_armed |=> tstate_r == RISM_WAIT && step_cnt_r == 8'h00 && cyc_cnt_r == 16'h0000)
        else $error("timer not armed at transmit end");
    // cycle counter wraps once per step
    a_step_wrap: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        tstate_r == RISM_WAIT |-> cyc_cnt_r < `RISM_STEP_CYCLES)
        else $error("step counter overran");

    // Checks
    a_read_clears: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        read_status && chip_en_in && set_vec == 8'h00 |=> status_r == 8'h00)
        else $error("status not cleared by read");
    a_sticky_hold: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        chip_en_in && !read_status |=> (status_r & $past(status_r)) == $past(status_r))
        else $error("status flag lost without read");
    a_en_low_clear: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        !chip_en_in |=> status_r == 8'h00)
        else $error("status not cleared with enable low");
    a_irq_txrx: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        status_r[7:6] != 2'b00 |-> irq_out)
        else $error("tx or rx flag without irq");
    a_irq_masked: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        status_r[7:6] == 2'b00 && (status_r[5:0] & mask_r[5:0]) == 6'h00 |-> !irq_out)
        else $error("irq without enabled cause");
    a_crc_off: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        chip_en_in && !crc_check_en_in && !status_r[4] && !read_status |=> !status_r[4])
        else $error("crc error with checking off");
    a_tx_end_set: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        chip_en_in && events_in.tx_done |=> status_r[7])
        else $error("tx end flag missing");
    a_mask_rsvd: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        mask_r[7:6] == 2'b00)
        else $error("reserved mask bits stored");
    a_noresp_set: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        chip_en_in && noresp_hit |=> status_r[0] ##1 tstate_r == RISM_IDLE || tstate_r == RISM_TX)
        else $error("no-response flag missing");
    a_irq_drop: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        read_status && chip_en_in && set_vec == 8'h00 |=> !irq_out)
        else $error("irq held after status read");
    // reply start or end sets bit 6
    a_rx_flag_set: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        chip_en_in && (events_in.rx_start || events_in.rx_done) |=> status_r[6])
        else $error("receive flag missing");
    a_hdr_set: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        chip_en_in && !alt_interrupt_mode_select_in && events_in.header_high |=> status_r[3])
        else $error("header flag missing");
    a_short_set: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        chip_en_in && events_in.short_reply |=> status_r[2])
        else $error("short reply flag missing");
    a_pre_set: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        chip_en_in && !alt_interrupt_mode_select_in && events_in.preamble_error |=> status_r[1])
        else $error("preamble flag missing");
    a_rx_fin_alt: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        chip_en_in && alt_interrupt_mode_select_in && events_in.rx_done |=> status_r[1])
        else $error("rx finished flag missing");
    // CRC error reported while checking is on
    a_crc_set: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        chip_en_in && crc_check_en_in && events_in.crc_error |=> status_r[4])
        else $error("crc flag missing");
    // an enabled cause always raises the line
    a_irq_cause: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (status_r[5:0] & mask_r[5:0]) != 6'h00 |-> irq_out)
        else $error("enabled cause without irq");
    // read returns the status held before the clear
    a_rdata_status: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        read_status |=> rdata_out == $past(status_r))
        else $error("status read data wrong");
    // mask write keeps only the used bits
    a_mask_write: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        chip_en_in && write_mask |=> mask_r == ($past(host_req_in.wdata) & `RISM_MASK_USED))
        else $error("mask write not stored");
endmodule : rism_irq

// ===== verification/rism_host_model.sv
// Host microcontroller model issuing register accesses
`timescale 1ns/1ps
module rism_host_model (
    input wire logic clk_in,
    output rism_pkg::rism_host_req_t host_req_out,
    input wire logic [7:0] rdata_in
);
    import rism_pkg::*;
    initial host_req_out = '0;
    // One access: strobe for one edge, data sampled one cycle later
    task automatic access(input logic [5:0] addr, input logic wr, input logic [7:0] wdata,
                          output logic [7:0] rdata);
        @(negedge clk_in);
        host_req_out = '{addr: addr, wr: wr, rd: !wr, wdata: wdata};
        @(negedge clk_in);
        rdata = rdata_in;
        // Released bus shows inverted junk, not the last value
        host_req_out = '{addr: ~addr, wr: 1'b0, rd: 1'b0, wdata: ~wdata};
    endtask : access
endmodule : rism_host_model

// ===== verification/testbench.sv
// Self-checking bench for the interrupt status and mask block
`timescale 1ns/1ps
`include "rism_defines.svh"
module testbench;
    import rism_pkg::*;
    logic clk_in = 1'b0;
    logic sys_rst_in = 1'b1;
    logic chip_en_in = 1'b1;
    rism_host_req_t host_req;
    rism_events_t events_in = '0;
    logic crc_en = 1'b1;
    logic alt_mode = 1'b0;
    logic transmitting = 1'b0;
    logic tx_dir = 1'b0;
    logic [4:0] fifo_lvl = 5'h00;
    logic [7:0] steps = 8'h00;
    logic [7:0] rdata_out;
    logic irq_out;
    logic [7:0] rd_val;
    int error_cnt = 0;
    int n_compared = 0;
    // FIFO level starts empty so no crossing follows reset
    rism_irq i_dut (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .chip_en_in(chip_en_in),
        .host_req_in(host_req), .events_in(events_in), .transmitting_in(transmitting),
        .tx_direction_in(tx_dir), .fifo_level_in(fifo_lvl), .crc_check_en_in(crc_en),
        .alt_interrupt_mode_select_in(alt_mode), .noresp_steps_in(steps),
        .rdata_out(rdata_out), .irq_out(irq_out));
    rism_host_model i_host (.clk_in(clk_in), .host_req_out(host_req), .rdata_in(rdata_out));
    initial begin
        forever #20 clk_in = ~clk_in;
    end
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic end_sim();
        if (error_cnt == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : end_sim
    task automatic fire(input rism_events_t ev);
        @(negedge clk_in);
        events_in = ev;
        @(negedge clk_in);
        events_in = '0;
    endtask : fire
    task automatic rd(input string what, input logic [5:0] addr, input logic [7:0] exp);
        i_host.access(addr, 1'b0, 8'h00, rd_val);
        check(what, rd_val, exp);
    endtask : rd
    task automatic wr_mask(input logic [7:0] val);
        i_host.access(`RISM_OFS_MASK, 1'b1, val, rd_val);
    endtask : wr_mask
    task automatic set_fifo(input logic [4:0] lvl);
        @(negedge clk_in);
        fifo_lvl = lvl;
    endtask : set_fifo
    // One transmission: busy level, then the end pulse
    task automatic tx_burst();
        @(negedge clk_in);
        transmitting = 1'b1;
        @(negedge clk_in);
        transmitting = 1'b0;
        fire('{tx_done: 1'b1, default: 1'b0});
    endtask : tx_burst
    // Transmit end raises unmaskable irq, read clears it
    task automatic t_tx_end();
        fire('{tx_done: 1'b1, default: 1'b0});
        check("irq tx", {7'h00, irq_out}, 8'h01);
        rd("status tx", `RISM_OFS_STATUS, 8'h80);
        check("irq after read", {7'h00, irq_out}, 8'h00);
        rd("status reread", `RISM_OFS_STATUS, 8'h00);
    endtask : t_tx_end
    // Reserved mask bits dropped, status writes refused
    task automatic t_refuse();
        wr_mask(8'hff);
        rd("mask rsvd", `RISM_OFS_MASK, 8'h3f);
        i_host.access(`RISM_OFS_STATUS, 1'b1, 8'hff, rd_val);
        rd("status wr", `RISM_OFS_STATUS, 8'h00);
    endtask : t_refuse
    // Causes in status bits 1 to 4 each raise irq with only their own mask bit set
    task automatic t_causes();
        for (int i = 1; i <= 4; i++) begin
            wr_mask(8'h01 << i);
            fire(rism_events_t'(7'h01 << (i - 1)));
            check("irq cause", {7'h00, irq_out}, 8'h01);
            rd("status cause", `RISM_OFS_STATUS, 8'h01 << i);
        end
        crc_en = 1'b0;
        fire('{crc_error: 1'b1, default: 1'b0});
        rd("crc off", `RISM_OFS_STATUS, 8'h00);
        crc_en = 1'b1;
    endtask : t_causes
    // Masked causes accumulate without irq
    task automatic t_accum();
        wr_mask(8'h00);
        fire('{short_reply: 1'b1, default: 1'b0});
        fire('{preamble_error: 1'b1, header_high: 1'b1, default: 1'b0});
        check("irq masked", {7'h00, irq_out}, 8'h00);
        rd("status acc", `RISM_OFS_STATUS, 8'h0e);
    endtask : t_accum
    // Alternate mode: rx done lands in bit 1 too
    task automatic t_alt();
        alt_mode = 1'b1;
        fire('{rx_done: 1'b1, default: 1'b0});
        check("irq rx", {7'h00, irq_out}, 8'h01);
        rd("status alt", `RISM_OFS_STATUS, 8'h42);
        alt_mode = 1'b0;
    endtask : t_alt
    // FIFO crossings in both directions, then the two byte mark
    task automatic t_fifo();
        wr_mask(8'h28);
        tx_dir = 1'b1;
        set_fifo(5'h08);
        set_fifo(5'h07);
        @(negedge clk_in);
        check("irq fifo low", {7'h00, irq_out}, 8'h01);
        rd("status fifo low", `RISM_OFS_STATUS, 8'h20);
        tx_dir = 1'b0;
        set_fifo(5'h10);
        set_fifo(5'h11);
        @(negedge clk_in);
        check("irq fifo high", {7'h00, irq_out}, 8'h01);
        rd("status fifo high", `RISM_OFS_STATUS, 8'h20);
        alt_mode = 1'b1;
        set_fifo(5'h01);
        set_fifo(5'h02);
        @(negedge clk_in);
        check("irq two bytes", {7'h00, irq_out}, 8'h01);
        rd("status two bytes", `RISM_OFS_STATUS, 8'h08);
        alt_mode = 1'b0;
        set_fifo(5'h00);
    endtask : t_fifo
    // Timer expires after its steps; a reply start stops it
    task automatic t_noresp();
        int cnt;
        logic ok;
        cnt = 0;
        wr_mask(8'h01);
        steps = 8'h02;
        tx_burst();
        rd("status tx armed", `RISM_OFS_STATUS, 8'h80);
        while (!irq_out && cnt < 2000) begin
            @(negedge clk_in);
            cnt++;
        end
        ok = cnt + 2 >= 2 * `RISM_STEP_CYCLES && cnt + 2 <= 2 * `RISM_STEP_CYCLES + 1;
        check("irq noresp", {7'h00, irq_out}, 8'h01);
        check("noresp time", {7'h00, ok}, 8'h01);
        rd("status noresp", `RISM_OFS_STATUS, 8'h01);
        steps = 8'h01;
        tx_burst();
        fire('{rx_start: 1'b1, default: 1'b0});
        repeat (700) @(negedge clk_in);
        rd("status reply", `RISM_OFS_STATUS, 8'hc0);
        steps = 8'h00;
    endtask : t_noresp
    // Chip enable low wipes status and mask
    task automatic t_chip_en();
        wr_mask(8'h3f);
        fire('{tx_done: 1'b1, default: 1'b0});
        chip_en_in = 1'b0;
        @(negedge clk_in);
        chip_en_in = 1'b1;
        check("irq chip off", {7'h00, irq_out}, 8'h00);
        rd("status chip off", `RISM_OFS_STATUS, 8'h00);
        rd("mask chip off", `RISM_OFS_MASK, 8'h00);
    endtask : t_chip_en
    // Bounded run guards against a hang
    initial begin
        repeat (5000) @(posedge clk_in);
        error_cnt++;
        end_sim();
    end
    initial begin
        repeat (6) @(posedge clk_in);
        @(negedge clk_in);
        sys_rst_in = 1'b0;
        rd("status reset", `RISM_OFS_STATUS, 8'h00);
        rd("mask reset", `RISM_OFS_MASK, 8'h00);
        t_tx_end();
        t_refuse();
        t_causes();
        t_accum();
        t_alt();
        t_fifo();
        t_noresp();
        t_chip_en();
        end_sim();
    end
endmodule : testbench
